// *** ccie_pkg.sv ***
// Constants shared by the clear-instruction execution block
package ccie_pkg;
  localparam int CCIE_DATA_W = 8;
  localparam int CCIE_FADDR_W = 7;
  localparam int CCIE_INSTR_W = 14;
  localparam int CCIE_ADDR_W = 4;
  localparam int CCIE_WDT_W = 8;
  localparam int CCIE_PRE_W = 8;

  // Opcode fields, top seven bits of the instruction word; clear-watchdog is matched on the whole 14-bit word
  localparam logic [6:0] CCIE_OP_CLEAR_FILE_REGISTER_OP = 7'h03;
  localparam logic [6:0] CCIE_OP_CLEAR_WORKING_REGISTER_OP = 7'h02;
  localparam logic [13:0] CCIE_OP_CLEAR_WATCHDOG_OP = 14'h0064;
  localparam int CCIE_OP_LSB = 7;

  // Register indices on the software port
  localparam logic [3:0] CCIE_REG_CTRL = 4'h0;
  localparam logic [3:0] CCIE_REG_STATUS = 4'h1;
  localparam logic [3:0] CCIE_REG_WORK = 4'h2;
  localparam logic [3:0] CCIE_REG_WDT = 4'h3;
  localparam logic [3:0] CCIE_REG_PRE = 4'h4;

  // Field positions
  localparam int CCIE_CTRL_WDT_EN = 0;
  localparam int CCIE_ST_ZERO = 2;
  localparam int CCIE_ST_PD_N = 3;
  localparam int CCIE_ST_TO_N = 4;

  // Reset values and the default prescaler limit
  localparam logic [7:0] CCIE_ZERO = 8'h00;
  localparam logic [7:0] CCIE_CTRL_RST = 8'h00;
  localparam logic CCIE_FLAG_N_RST = 1'b1;
  localparam logic [7:0] CCIE_PRE_LIMIT_DEF = 8'hff;

  function automatic logic ccie_is_clear_file_register_op(input logic [13:0] ins);
    return ins[13:CCIE_OP_LSB] == CCIE_OP_CLEAR_FILE_REGISTER_OP;
  endfunction : ccie_is_clear_file_register_op

  function automatic logic ccie_is_clear_working_register_op(input logic [13:0] ins);
    return ins[13:CCIE_OP_LSB] == CCIE_OP_CLEAR_WORKING_REGISTER_OP;
  endfunction : ccie_is_clear_working_register_op

  function automatic logic ccie_is_clear_watchdog_op(input logic [13:0] ins);
    return ins == CCIE_OP_CLEAR_WATCHDOG_OP;
  endfunction : ccie_is_clear_watchdog_op
endpackage : ccie_pkg

// *** ccie_clear_exec.sv ***
// Execution of the three clear instructions with watchdog and status
// Functional notes
// RQ1: Clear-file-register writes zero to the addressed register in one cycle.
// RQ2: Clear-file-register always sets the zero flag to one.
// RQ3: Clear-watchdog resets the watchdog counter to zero.
// RQ4: Clear-watchdog also zeroes the watchdog prescaler in the same cycle.
// RQ5: Clear-watchdog sets the timeout and power-down flags (active low) to one.
// RQ6: Clear-working-register zeroes W and sets the zero flag, no file access.
`timescale 1ns/100ps
module ccie_clear_exec
  import ccie_pkg::*;
#(
  parameter int DATA_W = ccie_pkg::CCIE_DATA_W,
  parameter int FADDR_W = ccie_pkg::CCIE_FADDR_W,
  parameter logic [7:0] PRE_LIMIT = ccie_pkg::CCIE_PRE_LIMIT_DEF
)
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic INSTR_VALID,
  input wire logic [ccie_pkg::CCIE_INSTR_W-1:0] INSTR,
  input wire logic WDT_TICK,
  input wire logic [ccie_pkg::CCIE_ADDR_W-1:0] ADDR,
  input wire logic [ccie_pkg::CCIE_DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [ccie_pkg::CCIE_DATA_W-1:0] RDATA,
  output logic FILE_WE,
  output logic [ccie_pkg::CCIE_FADDR_W-1:0] FILE_ADDR,
  output logic [ccie_pkg::CCIE_DATA_W-1:0] FILE_WDATA,
  output logic [ccie_pkg::CCIE_DATA_W-1:0] W_OUT,
  output logic ZERO_FLAG,
  output logic TIMEOUT_FLAG_N,
  output logic POWERDOWN_FLAG_N
);
  import ccie_pkg::*;

  // The datapath is fixed at the core's eight-bit word
  generate
    if (DATA_W != CCIE_DATA_W || FADDR_W != CCIE_FADDR_W)
    begin : g_bad_width
      $error("ccie_clear_exec: unsupported width");
    end
    if (PRE_LIMIT == CCIE_ZERO)
    begin : g_bad_limit
      $error("ccie_clear_exec: prescaler limit must be nonzero");
    end
  endgenerate

  logic clear_file_register_op_op;
  logic clear_working_register_op_op;
  logic clear_watchdog_op_op;

  logic tick_s1_q;
  logic tick_s2_q;
  logic tick_s3_q;
  logic tick_evt;

  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] work_q;
  logic [7:0] work_d;
  logic zero_q;
  logic zero_d;
  logic to_n_q;
  logic to_n_d;
  logic pd_n_q;
  logic pd_n_d;
  logic [7:0] wdt_q;
  logic [7:0] wdt_d;
  logic [7:0] pre_q;
  logic [7:0] pre_d;
  logic fwe_q;
  logic fwe_d;
  logic [6:0] fadr_q;
  logic [6:0] fadr_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  assign clear_file_register_op_op = INSTR_VALID && ccie_is_clear_file_register_op(INSTR);
  assign clear_working_register_op_op = INSTR_VALID && ccie_is_clear_working_register_op(INSTR);
  assign clear_watchdog_op_op = INSTR_VALID && ccie_is_clear_watchdog_op(INSTR);

  // Tick comes from the watchdog's own oscillator, so synchronise it
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      tick_s1_q <= 1'b0;
      tick_s2_q <= 1'b0;
      tick_s3_q <= 1'b0;
    end
    else
    begin
      tick_s1_q <= WDT_TICK;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
    end
  end

  assign tick_evt = tick_s2_q && !tick_s3_q;

  function automatic logic [7:0] read_mux(
    input logic [3:0] a,
    input logic [7:0] c,
    input logic [7:0] st,
    input logic [7:0] w,
    input logic [7:0] t,
    input logic [7:0] p
  );
    logic [7:0] r;
    r = CCIE_ZERO;
    unique case (a)
      CCIE_REG_CTRL: r = c;
      CCIE_REG_STATUS: r = st;
      CCIE_REG_WORK: r = w;
      CCIE_REG_WDT: r = t;
      CCIE_REG_PRE: r = p;
      default: r = CCIE_ZERO;
    endcase
    return r;
  endfunction : read_mux

  logic [7:0] status_rd;

  always_comb
  begin
    status_rd = CCIE_ZERO;
    status_rd[CCIE_ST_ZERO] = zero_q;
    status_rd[CCIE_ST_PD_N] = pd_n_q;
    status_rd[CCIE_ST_TO_N] = to_n_q;
  end

  always_comb
  begin
    ctrl_d = ctrl_q;
    work_d = work_q;
    zero_d = zero_q;
    to_n_d = to_n_q;
    pd_n_d = pd_n_q;
    wdt_d = wdt_q;
    pre_d = pre_q;
    fwe_d = 1'b0;
    fadr_d = fadr_q;
    rdata_d = CCIE_ZERO;

    // Software writes first, so an instruction in the same cycle wins
    if (WR)
    begin
      unique case (ADDR)
        CCIE_REG_CTRL: ctrl_d = WDATA;
        CCIE_REG_STATUS:
        begin
          zero_d = WDATA[CCIE_ST_ZERO];
          pd_n_d = WDATA[CCIE_ST_PD_N];
          to_n_d = WDATA[CCIE_ST_TO_N];
        end
        CCIE_REG_WORK: work_d = WDATA;
        default: ;
      endcase
    end
    if (RD)
    begin
      rdata_d = read_mux(ADDR, ctrl_q, status_rd, work_q, wdt_q, pre_q);
    end

    // Watchdog runs only while enabled; expiry pulls the timeout flag low
    if (ctrl_q[CCIE_CTRL_WDT_EN] && tick_evt)
    begin
      if (pre_q == PRE_LIMIT)
      begin
        pre_d = CCIE_ZERO;
        wdt_d = wdt_q + 8'h01;
        if (wdt_q == '1)
        begin
          to_n_d = 1'b0;
        end
      end
      else
      begin
        pre_d = pre_q + 8'h01;
      end
    end

    if (clear_file_register_op_op)
    begin
      fwe_d = 1'b1; // RQ1
      fadr_d = INSTR[FADDR_W-1:0]; // RQ1
      zero_d = 1'b1; // RQ2
    end
    if (clear_working_register_op_op)
    begin
      work_d = CCIE_ZERO; // RQ6
      zero_d = 1'b1; // RQ6
    end
    if (clear_watchdog_op_op)
    begin
      wdt_d = CCIE_ZERO; // RQ3
      pre_d = CCIE_ZERO; // RQ4
      to_n_d = 1'b1; // RQ5
      pd_n_d = 1'b1; // RQ5
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      ctrl_q <= CCIE_CTRL_RST;
      work_q <= CCIE_ZERO;
      zero_q <= 1'b0;
      to_n_q <= CCIE_FLAG_N_RST;
      pd_n_q <= CCIE_FLAG_N_RST;
      wdt_q <= CCIE_ZERO;
      pre_q <= CCIE_ZERO;
      fwe_q <= 1'b0;
      fadr_q <= '0;
      rdata_q <= CCIE_ZERO;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      work_q <= work_d;
      zero_q <= zero_d;
      to_n_q <= to_n_d;
      pd_n_q <= pd_n_d;
      wdt_q <= wdt_d;
      pre_q <= pre_d;
      fwe_q <= fwe_d;
      fadr_q <= fadr_d;
      rdata_q <= rdata_d;
    end
  end

  assign RDATA = rdata_q;
  assign FILE_WE = fwe_q;
  assign FILE_ADDR = fadr_q;
  // Cleared value is constant; no read of the file is ever needed
  assign FILE_WDATA = CCIE_ZERO;
  assign W_OUT = work_q;
  assign ZERO_FLAG = zero_q;
  assign TIMEOUT_FLAG_N = to_n_q;
  assign POWERDOWN_FLAG_N = pd_n_q;

  sequence s_clear_file_register_op;
    clear_file_register_op_op;
  endsequence

  sequence s_clear_working_register_op;
    clear_working_register_op_op;
  endsequence

  sequence s_clear_watchdog_op;
    clear_watchdog_op_op;
  endsequence

  sequence s_wdt_restart;
    (wdt_q == CCIE_ZERO) && (pre_q == CCIE_ZERO);
  endsequence

  clear_file_register_op_write_a: assert property (@(posedge CLK) disable iff (!RESETN) // RQ1
    s_clear_file_register_op |=> FILE_WE && FILE_WDATA == CCIE_ZERO
      && FILE_ADDR == $past(INSTR[FADDR_W-1:0]))
    else $error("clear-file write missing or wrong");

  we_cause_a: assert property (@(posedge CLK) disable iff (!RESETN) // RQ1
    FILE_WE |-> $past(clear_file_register_op_op))
    else $error("file write without clear-file");

  clear_file_register_op_zero_a: assert property (@(posedge CLK) disable iff (!RESETN) // RQ2
    s_clear_file_register_op |=> ZERO_FLAG)
    else $error("zero flag not set by clear-file");

  wdt_clear_a: assert property (@(posedge CLK) disable iff (!RESETN) // RQ3
    s_clear_watchdog_op |=> wdt_q == CCIE_ZERO)
    else $error("watchdog counter not cleared");

  pre_clear_a: assert property (@(posedge CLK) disable iff (!RESETN) // RQ4
    s_clear_watchdog_op |=> s_wdt_restart)
    else $error("prescaler not cleared with counter");

  flags_set_a: assert property (@(posedge CLK) disable iff (!RESETN) // RQ5
    s_clear_watchdog_op |=> TIMEOUT_FLAG_N && POWERDOWN_FLAG_N)
    else $error("timeout or power-down flag not set");

  clear_working_register_op_zero_a: assert property (@(posedge CLK) disable iff (!RESETN) // RQ6
    s_clear_working_register_op |=> W_OUT == CCIE_ZERO && ZERO_FLAG)
    else $error("working register or zero flag wrong");

  clear_working_register_op_nofile_a: assert property (@(posedge CLK) disable iff (!RESETN) // RQ6
    (s_clear_working_register_op and !clear_file_register_op_op) |=> !FILE_WE)
    else $error("clear-working touched the file");

  // A lone clear-file must leave exactly one write pulse behind
  we_single_a: assert property (@(posedge CLK) disable iff (!RESETN) // RQ1
    (s_clear_file_register_op ##1 !clear_file_register_op_op) |=> !FILE_WE)
    else $error("file write pulse longer than one cycle");

  // Same-cycle software write must not undo the instruction
  clear_file_register_op_beats_wr_a: assert property (@(posedge CLK) disable iff (!RESETN) // RQ2
    (s_clear_file_register_op and (WR && ADDR == CCIE_REG_STATUS)) |=> ZERO_FLAG)
    else $error("status write overrode clear-file");

  clear_working_register_op_beats_wr_a: assert property (@(posedge CLK) disable iff (!RESETN) // RQ6
    (s_clear_working_register_op and (WR && ADDR == CCIE_REG_WORK)) |=> W_OUT == CCIE_ZERO)
    else $error("working write overrode clear-working");
endmodule : ccie_clear_exec

// *** ccie_clear_exec_tb.sv ***
// Self-checking testbench for the clear-instruction execution block
`timescale 1ns/100ps
module ccie_clear_exec_tb;
  import ccie_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic instr_valid = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic wdt_tick = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [7:0] file_wdata;
  logic [7:0] w_out;
  logic [6:0] file_addr;
  logic file_we;
  logic zero_flag;
  logic to_n;
  logic pd_n;
  logic [7:0] v;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;

  always #25 clk = ~clk;

  // Short prescaler so a few ticks move the watchdog counter
  ccie_clear_exec #(.PRE_LIMIT(8'h01)) uut (
    .CLK(clk), .RESETN(resetn), .INSTR_VALID(instr_valid),
    .INSTR(instr), .WDT_TICK(wdt_tick), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .FILE_WE(file_we),
    .FILE_ADDR(file_addr), .FILE_WDATA(file_wdata), .W_OUT(w_out),
    .ZERO_FLAG(zero_flag), .TIMEOUT_FLAG_N(to_n),
    .POWERDOWN_FLAG_N(pd_n)
  );

  task automatic final_report;
    $display("Counts: %0d checks, %0d mismatches", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // Effects are sampled just after the taking edge has landed
  task automatic exec(input logic [13:0] ins);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= ins;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask : exec

  // Instruction and software write taken at the same edge
  task automatic exec_wr(input logic [13:0] ins, input logic [3:0] a,
                         input logic [7:0] d);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= ins;
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    instr_valid <= 1'b0;
    wr <= 1'b0;
    #1;
  endtask : exec_wr

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      err_count++;
      $display("[ERR] %0t run exceeded its cycle budget", $time);
      final_report();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    rd_reg(CCIE_REG_STATUS, v);
    chk(v, 8'h18);
    wr_reg(CCIE_REG_STATUS, 8'h00);
    exec(14'h01ff);
    chk({7'h00, file_we}, 8'h01);
    chk({1'b0, file_addr}, 8'h7f);
    chk(file_wdata, 8'h00);
    chk({7'h00, zero_flag}, 8'h01);
    @(posedge clk);
    #1 chk({7'h00, file_we}, 8'h00);
    $display("test clear-file done");
    wr_reg(CCIE_REG_WORK, 8'h5a);
    wr_reg(CCIE_REG_STATUS, 8'h00);
    exec(14'h0155);
    chk(w_out, 8'h00);
    chk({7'h00, zero_flag}, 8'h01);
    chk({7'h00, file_we}, 8'h00);
    rd_reg(CCIE_REG_WORK, v);
    chk(v, 8'h00);
    $display("test clear-working done");
    exec_wr(14'h0185, CCIE_REG_STATUS, 8'h00);
    chk({7'h00, zero_flag}, 8'h01);
    chk({1'b0, file_addr}, 8'h05);
    exec_wr(14'h0100, CCIE_REG_WORK, 8'ha5);
    chk(w_out, 8'h00);
    $display("test instruction-beats-write done");
    wr_reg(CCIE_REG_CTRL, 8'h01);
    // Odd tick count leaves the prescaler nonzero before the clear
    repeat (7)
    begin
      @(posedge clk);
      wdt_tick <= 1'b1;
      repeat (4) @(posedge clk);
      wdt_tick <= 1'b0;
      repeat (4) @(posedge clk);
    end
    rd_reg(CCIE_REG_WDT, v);
    chk(v, 8'h03);
    rd_reg(CCIE_REG_PRE, v);
    chk(v, 8'h01);
    wr_reg(CCIE_REG_STATUS, 8'h00);
    exec(CCIE_OP_CLEAR_WATCHDOG_OP);
    chk({7'h00, to_n}, 8'h01);
    chk({7'h00, pd_n}, 8'h01);
    rd_reg(CCIE_REG_WDT, v);
    chk(v, 8'h00);
    rd_reg(CCIE_REG_PRE, v);
    chk(v, 8'h00);
    rd_reg(CCIE_REG_STATUS, v);
    chk(v, 8'h18);
    $display("test clear-watchdog done");
    final_report();
  end
endmodule : ccie_clear_exec_tb
